// ===== hdl/raf_defines.svh
/*
  Register offsets, field positions and reset values of the receive
  address filter. Assumes a 32-bit register port with byte addresses.
*/
`ifndef RAF_DEFINES_SVH
`define RAF_DEFINES_SVH

`define RAF_OFS_CTRL    8'h00
`define RAF_OFS_SA1     8'h04
`define RAF_OFS_SA2     8'h08
`define RAF_OFS_SA3     8'h0C
`define RAF_OFS_HASHLO  8'h10
`define RAF_OFS_HASHHI  8'h14
`define RAF_OFS_STATUS  8'h18

`define RAF_BIT_PROMISC 3
`define RAF_BIT_MCALL   2
`define RAF_BIT_HASHEN  1
`define RAF_BIT_BCAST   0

`define RAF_CTRL_RST    4'h0
`define RAF_SA_RST      16'h0000
`define RAF_HASH_RST    64'h0000000000000000
`define RAF_BUF_DEPTH   2

`endif

// ===== hdl/raf_filter.sv
/*
  Destination-address filter of a MAC receiver: judges each frame's
  destination address and hands the verdict on through a two-entry buffer.
  Assumes one clock, registers on a plain strobe port, and a consumer
  that may stall by holding outReady low.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
// Operation
// - Control bit 3 set accepts every frame; clear applies address filtering.
// - Control bit 2 set accepts every multicast frame except broadcast, which follows control bit 0.
// - Control bit 1 enables hash-table multicast filtering; cleared disables it.
// - Control bit 0 set accepts all broadcast destination frames.
// - Unicast must match all six octets, first octet against word three.
`timescale 1ns/1ps
`include "raf_defines.svh"

module raf_filter #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output      logic [31:0]         regRdData,
  // Incoming destination addresses
  input  wire logic                rxValid,
  input  wire raf_pkg::raf_frame_t rxFrame,
  output      logic                rxReady,
  // Verdicts towards the receive FIFO
  output      logic                outValid,
  output raf_pkg::raf_verdict_t    outVerdict,
  input  wire logic                outReady
);
  import raf_pkg::*;

  raf_state_t  st;
  raf_state_t  next_st;
  logic [47:0] stationAddr;
  logic [5:0]  hashIdx;
  logic        isBcast;
  logic        isMcast;
  logic        isUcast;
  logic        ucMatch;
  logic        hashHit;
  logic        accept;
  logic        push;
  logic        pop;

  // Octet six of word three is the first octet on the wire
  assign stationAddr = {st.sa3[7:0], st.sa3[15:8], st.sa2[7:0],
                        st.sa2[15:8], st.sa1[7:0], st.sa1[15:8]};

  // Hash index folds the address; each index bit xors every sixth bit
  for (genvar b = 0; b < 6; b++) begin : g_hash
    assign hashIdx[b] = ^{rxFrame.dest[b], rxFrame.dest[b+6],
                          rxFrame.dest[b+12], rxFrame.dest[b+18],
                          rxFrame.dest[b+24], rxFrame.dest[b+30],
                          rxFrame.dest[b+36], rxFrame.dest[b+42]};
  end

  assign isBcast = &rxFrame.dest;
  assign isMcast = rxFrame.dest[40] && !isBcast;
  assign isUcast = !rxFrame.dest[40];
  assign ucMatch = (rxFrame.dest == stationAddr);
  assign hashHit = st.hash[hashIdx];

  always_comb begin
    accept = 1'b0;
    if (st.ctrl.promisc) begin
      accept = 1'b1;
    end else if (isBcast) begin
      accept = st.ctrl.bcastEn;
    end else if (isMcast) begin
      accept = st.ctrl.mcAll || (st.ctrl.hashEn && hashHit);
    end else begin
      accept = ucMatch;
    end
  end

  assign push = rxValid && st.inReady;
  assign pop  = (st.count != 2'd0) && outReady;

  always_comb begin
    next_st = st;
    // Register writes
    if (regWr) begin
      if (regAddr == `RAF_OFS_CTRL) begin
        next_st.ctrl = raf_ctrl_t'(regWrData[3:0]);
      end else if (regAddr == `RAF_OFS_SA1) begin
        next_st.sa1 = regWrData[15:0];
      end else if (regAddr == `RAF_OFS_SA2) begin
        next_st.sa2 = regWrData[15:0];
      end else if (regAddr == `RAF_OFS_SA3) begin
        next_st.sa3 = regWrData[15:0];
      end else if (regAddr == `RAF_OFS_HASHLO) begin
        next_st.hash[31:0] = regWrData;
      end else if (regAddr == `RAF_OFS_HASHHI) begin
        next_st.hash[63:32] = regWrData;
      end
    end
    // Read data stands only in the cycle after the strobe
    next_st.rdData = 32'h00000000;
    if (regRd) begin
      if (regAddr == `RAF_OFS_CTRL) begin
        next_st.rdData = {28'h0000000, st.ctrl};
      end else if (regAddr == `RAF_OFS_SA1) begin
        next_st.rdData = {16'h0000, st.sa1};
      end else if (regAddr == `RAF_OFS_SA2) begin
        next_st.rdData = {16'h0000, st.sa2};
      end else if (regAddr == `RAF_OFS_SA3) begin
        next_st.rdData = {16'h0000, st.sa3};
      end else if (regAddr == `RAF_OFS_HASHLO) begin
        next_st.rdData = st.hash[31:0];
      end else if (regAddr == `RAF_OFS_HASHHI) begin
        next_st.rdData = st.hash[63:32];
      end else if (regAddr == `RAF_OFS_STATUS) begin
        next_st.rdData = {st.rejCnt, st.accCnt};
      end
    end
    // Two-entry buffer, head in entry 0
    if (pop) begin
      next_st.entry[0] = st.entry[1];
    end
    if (push) begin
      next_st.entry[st.count - {1'b0, pop}] = '{dest: rxFrame.dest,
                                                accept: accept};
      if (accept) begin
        next_st.accCnt = st.accCnt + 16'h0001;
      end else begin
        next_st.rejCnt = st.rejCnt + 16'h0001;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    // Ready is registered from the next count, so it is withheld while the buffer holds two entries and until the first clock after reset
    next_st.inReady = (next_st.count != 2'd2);
    // Kept as its own flop so the output does not decode the count
    next_st.outValid = (next_st.count != 2'd0);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st.ctrl    <= raf_ctrl_t'(`RAF_CTRL_RST);
      st.sa1     <= `RAF_SA_RST;
      st.sa2     <= `RAF_SA_RST;
      st.sa3     <= `RAF_SA_RST;
      st.hash    <= `RAF_HASH_RST;
      st.entry   <= '0;
      st.count   <= 2'd0;
      st.inReady <= 1'b0;
      st.outValid <= 1'b0;
      st.rdData  <= 32'h00000000;
      st.accCnt  <= 16'h0000;
      st.rejCnt  <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData  = st.rdData;
  assign rxReady    = st.inReady;
  assign outValid   = st.outValid;
  assign outVerdict = st.entry[0];

  a_promisc_accepts: assert property (
    @(posedge clk) disable iff (sys_rst)
    push && st.ctrl.promisc |=> st.accCnt == $past(st.accCnt) + 16'h0001)
    else $error("promiscuous frame not accepted");

  a_mcall_accepts: assert property (
    @(posedge clk) disable iff (sys_rst)
    rxValid && isMcast && st.ctrl.mcAll |-> accept)
    else $error("multicast rejected with accept-all set");

  a_hash_off_rejects: assert property (
    @(posedge clk) disable iff (sys_rst)
    rxValid && isMcast && !st.ctrl.promisc && !st.ctrl.mcAll
      && !st.ctrl.hashEn |-> !accept)
    else $error("multicast accepted with hash filtering off");

  a_bcast_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    rxValid && isBcast && !st.ctrl.promisc |-> accept == st.ctrl.bcastEn)
    else $error("broadcast verdict differs from enable bit");

  a_ucast_first_octet: assert property (
    @(posedge clk) disable iff (sys_rst)
    rxValid && isUcast && !st.ctrl.promisc
      && rxFrame.dest[47:40] != st.sa3[7:0] |-> !accept)
    else $error("unicast accepted with first octet mismatch");

  a_hash_gates: assert property (
    @(posedge clk) disable iff (sys_rst)
    rxValid && isMcast && !st.ctrl.promisc && !st.ctrl.mcAll
      && st.ctrl.hashEn |-> accept == hashHit)
    else $error("hash verdict differs from table bit");

  a_verdict_reaches: assert property (
    @(posedge clk) disable iff (sys_rst)
    push && st.count == 2'd0 |=> outValid
      && outVerdict.dest == $past(rxFrame.dest)
      && outVerdict.accept == $past(accept))
    else $error("verdict not presented after push into empty buffer");

  a_no_overflow: assert property (
    @(posedge clk) disable iff (sys_rst)
    st.count == 2'd2 |-> !st.inReady)
    else $error("ready high with buffer full");

  a_read_one_cycle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !regRd |=> regRdData == 32'h00000000)
    else $error("read data stands beyond one cycle");

  a_stall_holds_verdict: assert property (
    @(posedge clk) disable iff (sys_rst)
    outValid && !outReady |=> outValid && $stable(outVerdict))
    else $error("verdict changed while stalled");

endmodule

// ===== hdl/raf_pkg.sv
/*
  Types shared by the receive address filter and its bench.
  Assumes the destination address arrives whole, first octet in [47:40].
*/
package raf_pkg;

  typedef struct packed {
    logic [47:0] dest;
  } raf_frame_t;

  typedef struct packed {
    logic [47:0] dest;
    logic        accept;
  } raf_verdict_t;

  typedef struct packed {
    logic promisc;
    logic mcAll;
    logic hashEn;
    logic bcastEn;
  } raf_ctrl_t;

  typedef struct packed {
    raf_ctrl_t         ctrl;
    logic [15:0]       sa1;
    logic [15:0]       sa2;
    logic [15:0]       sa3;
    logic [63:0]       hash;
    raf_verdict_t [1:0] entry;
    logic [1:0]        count;
    logic              inReady;
    logic              outValid;
    logic [31:0]       rdData;
    logic [15:0]       accCnt;
    logic [15:0]       rejCnt;
  } raf_state_t;

endpackage

// ===== verification/raf_filter_tb_top.sv
/*
  Bench of the receive address filter: register and frame tasks.
  Assumes the receive FIFO model collects the verdicts.
*/
`timescale 1ns/1ps
`include "raf_defines.svh"

module raf_filter_tb_top;
  import raf_pkg::*;
  localparam logic [47:0] ME = 48'h021122334455;
  localparam logic [47:0] MC = 48'h01005E000001;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  logic         clk, sys_rst, regWr, regRd, rxValid, rxReady;
  logic         outValid, outReady, stall;
  logic [7:0]   regAddr;
  logic [31:0]  regWrData, regRdData;
  logic [63:0]  hv;
  raf_frame_t   rxFrame;
  raf_verdict_t outVerdict;
  logic         exp[$];
  logic [47:0]  expD[$];
  int           err_count = 0;
  int           num_checks = 0;

  raf_filter DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rxValid(rxValid), .rxFrame(rxFrame),
    .rxReady(rxReady), .outValid(outValid), .outVerdict(outVerdict),
    .outReady(outReady));
  raf_rx_fifo_model FIFO (.clk(clk), .sys_rst(sys_rst),
    .outValid(outValid), .outVerdict(outVerdict), .outReady(outReady),
    .stall(stall));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [47:0] e, logic [47:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check("regRdData", e, regRdData);
    @(posedge clk);
  endtask

  // Leaves rxValid up so that the next call follows back to back
  task automatic send(logic [47:0] d, logic acc);
    int n = 0;
    rxValid <= 1'b1;
    rxFrame <= d;
    exp.push_back(acc);
    expD.push_back(d);
    do begin
      @(posedge clk);
      n++;
    end while (!rxReady && n < 50);
    if (!rxReady) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic flush();
    int n = 0;
    rxValid <= 1'b0;
    while (FIFO.got.size() < exp.size() && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (FIFO.got.size() < exp.size()) begin
      err_count++;
      wrap_up();
    end else begin
      check("verdicts", exp.size(), FIFO.got.size());
      foreach (exp[i]) begin
        check("accept", exp[i], FIFO.got[i].accept);
        check("dest", expD[i], FIFO.got[i].dest);
      end
      exp.delete();
      expD.delete();
      FIFO.got.delete();
    end
  endtask

  function automatic logic [5:0] hidx(logic [47:0] d);
    logic [5:0] h = 6'h00;
    for (int k = 0; k < 8; k++) h ^= d[6*k +: 6];
    return h;
  endfunction

  initial begin
    {sys_rst, regWr, regRd, rxValid, stall} = 5'h10;
    regAddr = 8'h00;
    regWrData = 32'h0;
    rxFrame = '0;
    hv = 64'h1 << hidx(MC);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`RAF_OFS_CTRL, 32'h0);
    rd(8'h1C, 32'h0);
    wr(`RAF_OFS_SA1, 32'h5544);
    wr(`RAF_OFS_SA2, 32'h3322);
    wr(`RAF_OFS_SA3, 32'h1102);
    rd(`RAF_OFS_SA3, 32'h1102);
    send(ME, 1'b1);
    send(ME ^ 48'h020000000000, 1'b0);
    send(ME ^ 48'h1, 1'b0);
    send(BC, 1'b0);
    send(MC, 1'b0);
    flush();
    wr(`RAF_OFS_CTRL, 32'h1);
    send(BC, 1'b1);
    flush();
    wr(`RAF_OFS_CTRL, 32'h4);
    send(MC, 1'b1);
    send(BC, 1'b0);
    flush();
    wr(`RAF_OFS_HASHLO, hv[31:0]);
    wr(`RAF_OFS_HASHHI, hv[63:32]);
    rd(`RAF_OFS_HASHHI, hv[63:32]);
    wr(`RAF_OFS_CTRL, 32'h2);
    send(MC, 1'b1);
    send(MC ^ 48'h1, 1'b0);
    flush();
    wr(`RAF_OFS_CTRL, 32'h8);
    send(ME ^ 48'h1, 1'b1);
    send(MC ^ 48'h1, 1'b1);
    flush();
    wr(`RAF_OFS_CTRL, 32'h0);
    stall <= 1'b1;
    for (int i = 0; i < 6; i++) send(i[0] ? ME ^ 48'h1 : ME, !i[0]);
    flush();
    rd(`RAF_OFS_STATUS, 32'h00090009);
    // Reset in mid-run must clear counters, table and station words
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`RAF_OFS_STATUS, 32'h0);
    rd(`RAF_OFS_HASHLO, 32'h0);
    rd(`RAF_OFS_SA3, 32'h0);
    wrap_up();
  end
endmodule

// ===== verification/raf_rx_fifo_model.sv
/*
  Receive FIFO model: takes verdicts and keeps them in arrival order.
  Assumes the filter's verdict stream on the same clock.
*/
`timescale 1ns/1ps

module raf_rx_fifo_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Verdict stream
  input  wire logic                  outValid,
  input  wire raf_pkg::raf_verdict_t outVerdict,
  output      logic                  outReady,
  // Test control
  input  wire logic                  stall
);
  import raf_pkg::*;
  raf_verdict_t got[$];
  logic [1:0]   phase;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase    <= 2'h0;
      outReady <= 1'b0;
    end else begin
      phase    <= phase + 2'h1;
      // Ready one cycle in four so that the buffer fills and refuses
      outReady <= !stall || (phase == 2'h0);
      if (outValid && outReady) begin
        got.push_back(outVerdict);
      end
    end
  end
endmodule
